// [design/odc_pkg.sv]
// package: register map, field layout and default codes of the offset code control
//------------------------------------------------------------------------------
// Behaviour
// RULE_01: two independent 12-bit offset codes, group A and group B.
// RULE_02: larger code moves group outputs more negative; offset code drives the shift.
// RULE_03: on reset each code takes the default for data format and gain.
// RULE_04: a gain change overwrites both codes with the new gain default.
// RULE_05: straight binary defaults 99Ah for gain six, AABh for gain four, trim +-1.
// RULE_06: zero negative rail powers down both offset converters, outputs high impedance; the code clears power-down while RESET is high.
// RULE_07: software should keep default codes for best symmetric bipolar accuracy.
// RULE_08: code is straight binary with format select low, twos complement when high.
// RULE_09: gain for default selection comes from the configuration gain bit.
// RULE_10: reads return the applied code, in the format it was written; the code converts it with the format select in force at the read.
//------------------------------------------------------------------------------
package odc_pkg;
    localparam int          CODE_W         = 12;
    localparam logic [11:0] OFS_A_ADDR     = 12'h000;
    localparam logic [11:0] OFS_B_ADDR     = 12'h004;
    localparam logic [11:0] CONFIG_ADDR    = 12'h008;
    localparam logic [11:0] STATUS_ADDR    = 12'h00C;
    localparam logic [11:0] TRIM_ADDR      = 12'h010;
    localparam int          CFG_GAIN_BIT   = 0;
    localparam logic        CFG_GAIN_RST   = 1'b1;
    localparam logic [11:0] DEF_GAIN6_SB   = 12'h99A;
    localparam logic [11:0] DEF_GAIN4_SB   = 12'hAAB;
    localparam logic [11:0] FMT_FLIP       = 12'h800;
    localparam logic [1:0]  TRIM_RST       = 2'h0;
    localparam int          ST_GAIN_BIT    = 0;
    localparam int          ST_FMT_BIT     = 1;
    localparam int          ST_SINGLE_BIT  = 2;
    localparam int          ST_PD_BIT      = 3;
endpackage

// [design/odc_code_reg.sv]
// one offset code holder with default reload and format conversion
`timescale 1ns/1ps
module odc_code_reg
    import odc_pkg::*;
(
    input  wire logic              clk,       // system clock
    input  wire logic              rst,       // synchronous reset, high
    input  wire logic              load_def,  // reload the default code
    input  wire logic              gain6,     // 1 = gain six
    input  wire logic              fmt_btc,   // 1 = twos complement format
    input  wire logic [1:0]        trim,      // factory trim: 0 none, 1 +1, 2 -1
    input  wire logic              wr,        // software write
    input  wire logic [CODE_W-1:0] wdata,     // written code, in the active format
    output logic      [CODE_W-1:0] code_sb,   // applied code, straight binary
    output logic      [CODE_W-1:0] code_rd    // code in the active format
);
    logic [CODE_W-1:0] code_r;
    logic [CODE_W-1:0] code_nxt;
    logic [CODE_W-1:0] def_sb;

    always_comb begin
        def_sb = gain6 ? DEF_GAIN6_SB : DEF_GAIN4_SB; // RULE_05
        if (trim == 2'h1) begin
            def_sb = def_sb + 12'h001;
        end else if (trim == 2'h2) begin
            def_sb = def_sb - 12'h001;
        end
        code_nxt = code_r;
        if (rst || load_def) begin
            code_nxt = def_sb; // RULE_03 RULE_04
        end else if (wr) begin
            code_nxt = fmt_btc ? (wdata ^ FMT_FLIP) : wdata; // RULE_08
        end
    end

    always_ff @(posedge clk) begin
        code_r <= code_nxt;
    end

    assign code_sb = code_r;
    assign code_rd = fmt_btc ? (code_r ^ FMT_FLIP) : code_r; // RULE_10
endmodule

// [design/odc_top.sv]
// offset code control: APB registers, two group offset codes, power-down
`timescale 1ns/1ps
module odc_top
    import odc_pkg::*;
(
    input  wire logic        CLK_SYS,     // 40 MHz system clock
    input  wire logic        RESET,       // synchronous reset, high
    input  wire logic        PSEL,        // apb select
    input  wire logic        PENABLE,     // apb enable
    input  wire logic        PWRITE,      // apb direction
    input  wire logic [11:0] PADDR,       // apb byte address
    input  wire logic [31:0] PWDATA,      // apb write data
    output logic      [31:0] PRDATA,      // apb read data
    output logic             PREADY,      // apb ready
    output logic             PSLVERR,     // apb error
    input  wire logic        DATA_FORMAT_SELECT, // pin: 0 straight binary, 1 twos compl.
    input  wire logic        SINGLE_SUPPLY,      // pin: negative rail is zero
    output logic      [11:0] OFS_CODE_A,  // applied code group A, straight binary
    output logic      [11:0] OFS_CODE_B,  // applied code group B, straight binary
    output logic             OFS_PD_A,    // group A offset converter powered down
    output logic             OFS_PD_B,    // group B offset converter powered down
    output logic             OFS_HIZ_A,   // group A amplifier high impedance
    output logic             OFS_HIZ_B    // group B amplifier high impedance
);
    //--------------------------------------------------------------------------
    // pin synchronisers
    //--------------------------------------------------------------------------
    logic [1:0] fmt_sync_r;
    logic [1:0] fmt_sync_nxt;
    logic [1:0] ss_sync_r;
    logic [1:0] ss_sync_nxt;
    logic       fmt_btc;
    logic       single;

    always_comb begin
        fmt_sync_nxt = {fmt_sync_r[0], DATA_FORMAT_SELECT};
        ss_sync_nxt  = {ss_sync_r[0], SINGLE_SUPPLY};
    end

    always_ff @(posedge CLK_SYS) begin
        fmt_sync_r <= fmt_sync_nxt;
        ss_sync_r  <= ss_sync_nxt;
    end

    assign fmt_btc = fmt_sync_r[1];
    assign single  = ss_sync_r[1];

    //--------------------------------------------------------------------------
    // apb slave and configuration
    //--------------------------------------------------------------------------
    logic        gain6_r;
    logic        gain6_nxt;
    logic [1:0]  trim_a_r;
    logic [1:0]  trim_a_nxt;
    logic [1:0]  trim_b_r;
    logic [1:0]  trim_b_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pready_r;
    logic        pready_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;
    logic        pd_r;
    logic        pd_nxt;
    logic        acc;
    logic        wr_a;
    logic        wr_b;
    logic        gain_chg;
    logic [11:0] code_a_sb;
    logic [11:0] code_b_sb;
    logic [11:0] code_a_rd;
    logic [11:0] code_b_rd;

    // address decode, one hit per mapped register
    logic        hit_a;
    logic        hit_b;
    logic        hit_cfg;
    logic        hit_st;
    logic        hit_trim;
    logic        hit_none;

    always_comb begin
        hit_a    = 1'b0;
        hit_b    = 1'b0;
        hit_cfg  = 1'b0;
        hit_st   = 1'b0;
        hit_trim = 1'b0;
        hit_none = 1'b0;
        if (PADDR == OFS_A_ADDR) begin
            hit_a = 1'b1;
        end else if (PADDR == OFS_B_ADDR) begin
            hit_b = 1'b1;
        end else if (PADDR == CONFIG_ADDR) begin
            hit_cfg = 1'b1;
        end else if (PADDR == STATUS_ADDR) begin
            hit_st = 1'b1;
        end else if (PADDR == TRIM_ADDR) begin
            hit_trim = 1'b1;
        end else begin
            hit_none = 1'b1;
        end
    end

    // one wait state: answer on the second access cycle
    assign acc  = PSEL && PENABLE && pready_r;
    assign wr_a = acc && PWRITE && hit_a;
    assign wr_b = acc && PWRITE && hit_b;

    always_comb begin
        gain6_nxt   = gain6_r;
        trim_a_nxt  = trim_a_r;
        trim_b_nxt  = trim_b_r;
        prdata_nxt  = 32'h0000_0000;
        pready_nxt  = PSEL && PENABLE && !pready_r;
        pslverr_nxt = 1'b0;
        gain_chg    = 1'b0;
        if (PSEL && PENABLE && !pready_r) begin
            if (hit_a) begin
                prdata_nxt = {20'h00000, code_a_rd}; // RULE_10
            end else if (hit_b) begin
                prdata_nxt = {20'h00000, code_b_rd}; // RULE_10
            end else if (hit_cfg) begin
                prdata_nxt[CFG_GAIN_BIT] = gain6_r;
            end else if (hit_st) begin
                prdata_nxt[ST_GAIN_BIT]   = gain6_r;
                prdata_nxt[ST_FMT_BIT]    = fmt_btc;
                prdata_nxt[ST_SINGLE_BIT] = single;
                prdata_nxt[ST_PD_BIT]     = pd_r;
            end else if (hit_trim) begin
                prdata_nxt = {28'h0000000, trim_b_r, trim_a_r};
            end else if (hit_none) begin
                pslverr_nxt = 1'b1;
            end
            // status is read only
            if (PWRITE && hit_st) begin
                pslverr_nxt = 1'b1;
            end
        end
        if (acc && PWRITE) begin
            if (hit_cfg) begin
                gain6_nxt = PWDATA[CFG_GAIN_BIT]; // RULE_09
                gain_chg  = (PWDATA[CFG_GAIN_BIT] != gain6_r); // RULE_04
            end else if (hit_trim) begin
                trim_a_nxt = PWDATA[1:0];
                trim_b_nxt = PWDATA[3:2];
            end
        end
        if (RESET) begin
            gain6_nxt   = CFG_GAIN_RST;
            trim_a_nxt  = TRIM_RST;
            trim_b_nxt  = TRIM_RST;
            prdata_nxt  = 32'h0000_0000;
            pready_nxt  = 1'b0;
            pslverr_nxt = 1'b0;
        end
        pd_nxt = RESET ? 1'b0 : single; // RULE_06
    end

    always_ff @(posedge CLK_SYS) begin
        gain6_r   <= gain6_nxt;
        trim_a_r  <= trim_a_nxt;
        trim_b_r  <= trim_b_nxt;
        prdata_r  <= prdata_nxt;
        pready_r  <= pready_nxt;
        pslverr_r <= pslverr_nxt;
        pd_r      <= pd_nxt;
    end

    //--------------------------------------------------------------------------
    // group offset codes
    //--------------------------------------------------------------------------
    // the new gain is used by the reload on the edge after the config write
    logic gain_chg_r;
    logic gain_chg_nxt;

    always_comb begin
        gain_chg_nxt = RESET ? 1'b0 : gain_chg;
    end

    always_ff @(posedge CLK_SYS) begin
        gain_chg_r <= gain_chg_nxt;
    end

    odc_code_reg u_code_a ( // RULE_01
        .clk      (CLK_SYS),
        .rst      (RESET),
        .load_def (gain_chg_r),
        .gain6    (gain6_r),
        .fmt_btc  (fmt_btc),
        .trim     (trim_a_r),
        .wr       (wr_a && !gain_chg_r),
        .wdata    (PWDATA[11:0]),
        .code_sb  (code_a_sb),
        .code_rd  (code_a_rd)
    );

    odc_code_reg u_code_b ( // RULE_01
        .clk      (CLK_SYS),
        .rst      (RESET),
        .load_def (gain_chg_r),
        .gain6    (gain6_r),
        .fmt_btc  (fmt_btc),
        .trim     (trim_b_r),
        .wr       (wr_b && !gain_chg_r),
        .wdata    (PWDATA[11:0]),
        .code_sb  (code_b_sb),
        .code_rd  (code_b_rd)
    );

    //--------------------------------------------------------------------------
    // registered outputs
    //--------------------------------------------------------------------------
    logic [11:0] out_a_r;
    logic [11:0] out_b_r;
    logic [11:0] out_a_nxt;
    logic [11:0] out_b_nxt;

    always_comb begin
        out_a_nxt = code_a_sb; // RULE_02
        out_b_nxt = code_b_sb; // RULE_02
    end

    always_ff @(posedge CLK_SYS) begin
        out_a_r <= out_a_nxt;
        out_b_r <= out_b_nxt;
    end

    assign PRDATA     = prdata_r;
    assign PREADY     = pready_r;
    assign PSLVERR    = pslverr_r;
    assign OFS_CODE_A = out_a_r;
    assign OFS_CODE_B = out_b_r;
    assign OFS_PD_A   = pd_r; // RULE_06
    assign OFS_PD_B   = pd_r;
    assign OFS_HIZ_A  = pd_r;
    assign OFS_HIZ_B  = pd_r;
endmodule

// [verification/odc_top_sva.sv]
// checker: bus timing, default codes and power-down of the offset code control
`timescale 1ns/1ps
module odc_top_sva
    import odc_pkg::*;
(
    input wire logic        CLK_SYS,       // clock
    input wire logic        RESET,         // reset
    input wire logic        PSEL,          // select
    input wire logic        PENABLE,       // enable
    input wire logic        PWRITE,        // direction
    input wire logic [11:0] PADDR,         // address
    input wire logic [31:0] PRDATA,        // read data
    input wire logic        PREADY,        // ready
    input wire logic        PSLVERR,       // error
    input wire logic        SINGLE_SUPPLY, // supply pin
    input wire logic [11:0] OFS_CODE_A,    // code a
    input wire logic [11:0] OFS_CODE_B,    // code b
    input wire logic        OFS_PD_A,      // down a
    input wire logic        OFS_PD_B,      // down b
    input wire logic        OFS_HIZ_A,     // hiz a
    input wire logic        OFS_HIZ_B      // hiz b
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    sequence s_setup; PSEL && !PENABLE; endsequence
    sequence s_wait; PSEL && PENABLE && !PREADY; endsequence
    sequence s_take; PSEL && PENABLE && PREADY; endsequence
    property p_wait; s_setup ##1 s_wait |=> PREADY; endproperty
    a_wait: assert property (p_wait) else $error("ready late");
    property p_pulse; PREADY |=> !PREADY; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_idle; !PREADY |-> PRDATA == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("data while idle");
    property p_upper; PREADY |-> PRDATA[31:12] == 20'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    property p_err;
        s_take ##0 (PADDR > TRIM_ADDR || (PWRITE && PADDR == STATUS_ADDR)) |-> PSLVERR;
    endproperty
    a_err: assert property (p_err) else $error("no error flag");
    property p_pair; OFS_PD_A |-> OFS_PD_B && OFS_HIZ_A && OFS_HIZ_B; endproperty
    a_pair: assert property (p_pair) else $error("groups differ");
    property p_follow; ($stable(SINGLE_SUPPLY))[*4] |-> OFS_PD_A == SINGLE_SUPPLY; endproperty
    a_follow: assert property (p_follow) else $error("power-down wrong");
    property p_rst; $fell(RESET) |-> OFS_CODE_A == DEF_GAIN6_SB && OFS_CODE_B == DEF_GAIN6_SB;
    endproperty
    a_rst: assert property (p_rst) else $error("no reset default");
endmodule

// [verification/tb_odc_top.sv]
// testbench: bus sequences for the offset code control
`timescale 1ns/1ps
module tb_odc_top;
    import odc_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic        fmt = 1'b0;
    logic        single = 1'b0;
    logic [31:0] prdata, rd;
    logic [11:0] code_a, code_b;
    logic        pready, pslverr, er, pd_a, pd_b, hz_a, hz_b;
    int          errors = 0;
    int          n_checks = 0;
    odc_top u_dut (.CLK_SYS(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .DATA_FORMAT_SELECT(fmt), .SINGLE_SUPPLY(single),
        .OFS_CODE_A(code_a), .OFS_CODE_B(code_b), .OFS_PD_A(pd_a), .OFS_PD_B(pd_b),
        .OFS_HIZ_A(hz_a), .OFS_HIZ_B(hz_b));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("ERROR %0t: saw %h wanted %h", $time, s, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 50) begin
            k++;
            @(posedge clk);
        end
        if (pready !== 1'b1) begin
            errors++;
            $display("ERROR %0t: no ready from slave", $time);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task pins(input logic [11:0] a, input logic [11:0] b);
        repeat (3) @(negedge clk);
        chk({20'h0, code_a}, {20'h0, a});
        chk({20'h0, code_b}, {20'h0, b});
    endtask
    task do_reset;
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        $display("ERROR %0t: watchdog expired", $time);
        wrap_up();
    end
    initial begin
        do_reset();
        rdc(OFS_B_ADDR, 32'h99A);
        rdc(CONFIG_ADDR, 32'h1);
        pins(12'h99A, 12'h99A);
        apb(1'b1, OFS_A_ADDR, 32'h123);
        apb(1'b1, OFS_B_ADDR, 32'hFFF);
        rdc(OFS_A_ADDR, 32'h123);
        pins(12'h123, 12'hFFF);
        apb(1'b1, CONFIG_ADDR, 32'h0);
        pins(12'hAAB, 12'hAAB);
        rdc(STATUS_ADDR, 32'h0);
        apb(1'b1, OFS_A_ADDR, 32'h10);
        apb(1'b1, CONFIG_ADDR, 32'h0);
        pins(12'h010, 12'hAAB);
        apb(1'b1, TRIM_ADDR, 32'h9);
        rdc(TRIM_ADDR, 32'h9);
        apb(1'b1, CONFIG_ADDR, 32'h1);
        pins(12'h99B, 12'h999);
        @(posedge clk);
        fmt <= 1'b1;
        repeat (4) @(posedge clk);
        rdc(OFS_A_ADDR, 32'h19B);
        apb(1'b1, OFS_B_ADDR, 32'h7FF);
        pins(12'h99B, 12'hFFF);
        rdc(OFS_B_ADDR, 32'h7FF);
        apb(1'b1, 12'h020, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, STATUS_ADDR, 32'h0);
        chk({31'h0, er}, 32'h1);
        single <= 1'b1;
        repeat (5) @(posedge clk);
        rdc(STATUS_ADDR, 32'hF);
        chk({28'h0, pd_a, pd_b, hz_a, hz_b}, 32'hF);
        single <= 1'b0;
        repeat (5) @(posedge clk);
        chk({28'h0, pd_a, pd_b, hz_a, hz_b}, 32'h0);
        @(posedge clk);
        do_reset();
        rdc(OFS_A_ADDR, 32'h19A);
        rdc(OFS_B_ADDR, 32'h19A);
        wrap_up();
    end
endmodule
bind odc_top odc_top_sva u_sva (.CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SINGLE_SUPPLY(SINGLE_SUPPLY), .OFS_CODE_A(OFS_CODE_A),
    .OFS_CODE_B(OFS_CODE_B), .OFS_PD_A(OFS_PD_A), .OFS_PD_B(OFS_PD_B),
    .OFS_HIZ_A(OFS_HIZ_A), .OFS_HIZ_B(OFS_HIZ_B));
